// file: shared/clk_sel_pkg.sv
// constants and types for the processor clock source selector
//------------------------------------------------------------
//------------------------------------------------------------
package clk_sel_pkg;

  // clock source of the processor
  typedef enum logic [1:0] {SRC_INPUT, SRC_SYNTH, SRC_SLOW} src_t;

  // defaults of the block parameters
  localparam int SYNTH_MULT     = 4;     // synthesizer multiple of the input clock
  localparam int SLOW_DIV       = 64;    // core cycles per slow clock tick
  localparam int MIN_GAP        = 2;     // least core cycles between processor ticks
  localparam int SWITCH_TIMEOUT = 255;   // idle cycles before forcing a switch
  localparam int CNT_W          = 16;    // width of period and phase counters
  localparam int LOCK_EDGES     = 2;     // input edges measured before lock

  // values after reset
  localparam logic       RST_SYNTH_PWR = 1'h0;
  localparam logic [1:0] RST_ACTIVE    = 2'h0;

endpackage : clk_sel_pkg

// file: hdl/freq_synth.sv
// frequency synthesizer model producing MULT ticks per input clock period
`timescale 1ns/10ps
module freq_synth #(
  parameter int MULT  = clk_sel_pkg::SYNTH_MULT,
  parameter int CNT_W = clk_sel_pkg::CNT_W
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // control and reference
  input  wire logic power_on,
  input  wire logic ref_edge,
  // output
  output logic      tick,
  output logic      locked
);

  logic [CNT_W-1:0] per_cnt_q;
  logic [CNT_W-1:0] period_q;
  logic [CNT_W-1:0] phase_q;
  logic [CNT_W-1:0] issued_q;
  logic [1:0]       edges_q;
  logic [CNT_W-1:0] step;
  logic             mid_tick;

  // spacing of ticks inside one input period, at least one cycle
  always_comb
  begin
    step = period_q / CNT_W'(MULT);
    if (step == '0)
      step = CNT_W'(1);
  end

  assign mid_tick = locked && !ref_edge && (phase_q == step - CNT_W'(1))
                    && (issued_q < CNT_W'(MULT));

  // ticks: one on each input edge, the rest evenly spaced
  assign tick = power_on && locked && (ref_edge || mid_tick);

  // measure the input clock period
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      per_cnt_q <= '0;
      period_q  <= '0;
    end
    else if (!power_on)
    begin
      per_cnt_q <= '0;
      period_q  <= '0;
    end
    else if (ref_edge)
    begin
      per_cnt_q <= '0;
      period_q  <= per_cnt_q + CNT_W'(1);
    end
    else if (per_cnt_q != '1)
      per_cnt_q <= per_cnt_q + CNT_W'(1);
  end

  // phase within the period and number of ticks issued
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_q  <= '0;
      issued_q <= '0;
    end
    else if (!power_on || ref_edge)
    begin
      phase_q  <= '0;
      issued_q <= CNT_W'(1);
    end
    else if (mid_tick)
    begin
      phase_q  <= '0;
      issued_q <= issued_q + CNT_W'(1);
    end
    else if (phase_q != '1)
      phase_q <= phase_q + CNT_W'(1);
  end

  // lock once enough input periods have been measured
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      edges_q <= '0;
    else if (!power_on)
      edges_q <= '0;
    else if (ref_edge && edges_q != 2'(clk_sel_pkg::LOCK_EDGES))
      edges_q <= edges_q + 2'h1;
  end

  assign locked = power_on && (edges_q == 2'(clk_sel_pkg::LOCK_EDGES));

endmodule : freq_synth

// file: hdl/clk_source_sel.sv
// processor clock source selector producing a processor clock enable
`timescale 1ns/10ps
module clk_source_sel #(
  parameter int MULT           = clk_sel_pkg::SYNTH_MULT,
  parameter int SLOW_DIV       = clk_sel_pkg::SLOW_DIV,
  parameter int MIN_GAP        = clk_sel_pkg::MIN_GAP,
  parameter int SWITCH_TIMEOUT = clk_sel_pkg::SWITCH_TIMEOUT
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // external input clocks, sampled levels
  input  wire logic       ext_clock_in,
  input  wire logic       ext_clock_in_alt,
  input  wire logic       alt_in_sel,
  // source selections from software
  input  wire logic       synth_sel,
  input  wire logic       slow_sel,
  // external stop pin
  input  wire logic       clk_stop,
  // processor clock and status
  output logic            proc_clk_en,
  output logic [1:0]      active_src,
  output logic            synth_powered,
  output logic            synth_locked,
  output logic            clk_stopped
);

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  // one step of a cycle counter that stops at its top value
  function automatic logic [7:0] sat_inc8(input logic [7:0] value);
    if (value == 8'hFF)
      return value;
    else
      return value + 8'h01;
  endfunction : sat_inc8

  //------------------------------------------------------------
  // input clock edge detection
  //------------------------------------------------------------
  logic in_q;
  logic in_prev_q;
  logic in_rise;

  // sample the chosen input pin, one tick per rising edge
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      in_q      <= 1'h0;
      in_prev_q <= 1'h0;
    end
    else
    begin
      in_q      <= alt_in_sel ? ext_clock_in_alt : ext_clock_in;
      in_prev_q <= in_q;
    end
  end

  // a pin already high at release counts as a rise; MIN_GAP spaces the first phase
  assign in_rise = in_q && !in_prev_q;

  //------------------------------------------------------------
  // synthesizer power and instance
  //------------------------------------------------------------
  logic synth_pwr_q;
  logic synth_tick;
  logic synth_lock;

  // powered only by its own selection, so the slow clock leaves it running
  // deselecting it powers it down on the next core cycle, whatever the active source
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      synth_pwr_q <= clk_sel_pkg::RST_SYNTH_PWR;
    else
      synth_pwr_q <= synth_sel;
  end

  freq_synth #(
    .MULT  (MULT),
    .CNT_W (clk_sel_pkg::CNT_W)
  ) u_synth (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .power_on (synth_pwr_q),
    .ref_edge (in_rise),
    .tick     (synth_tick),
    .locked   (synth_lock)
  );

  //------------------------------------------------------------
  // slow clock divider
  //------------------------------------------------------------
  logic [15:0] slow_cnt_q;
  logic        slow_tick;

  // one enable pulse every SLOW_DIV core cycles
  // free running: the first slow phase after a switch may be short, MIN_GAP still holds
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      slow_cnt_q <= '0;
    else if (slow_cnt_q == 16'(SLOW_DIV - 1))
      slow_cnt_q <= '0;
    else
      slow_cnt_q <= slow_cnt_q + 16'h0001;
  end

  assign slow_tick = (slow_cnt_q == 16'(SLOW_DIV - 1));

  //------------------------------------------------------------
  // source choice and clean switching
  //------------------------------------------------------------
  clk_sel_pkg::src_t want_src;
  clk_sel_pkg::src_t cur_src_q;
  logic              cur_tick;
  logic [7:0]        gap_q;
  logic [7:0]        idle_q;
  logic              do_switch;
  logic              emit;

  // slow clock first, synthesizer only once locked, else the input clock
  // an unlocked synthesizer is never used, so no half-measured period reaches the core
  always_comb
  begin
    if (slow_sel)
      want_src = clk_sel_pkg::SRC_SLOW;
    else if (synth_sel && synth_lock)
      want_src = clk_sel_pkg::SRC_SYNTH;
    else
      want_src = clk_sel_pkg::SRC_INPUT;
  end

  // tick of the source now driving the processor
  // ticks of the other sources never reach the processor
  always_comb
  begin
    unique case (cur_src_q)
      clk_sel_pkg::SRC_INPUT: cur_tick = in_rise;
      clk_sel_pkg::SRC_SYNTH: cur_tick = synth_tick;
      clk_sel_pkg::SRC_SLOW:  cur_tick = slow_tick;
      default:                cur_tick = 1'h0;
    endcase
  end

  // change only on a boundary of the old source, or once it has gone quiet;
  // quiet is judged on the old source, so a stopped processor cannot hold it back
  assign do_switch = (want_src != cur_src_q)
                     && (cur_tick || idle_q >= 8'(SWITCH_TIMEOUT));

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      cur_src_q <= clk_sel_pkg::SRC_INPUT;
    else if (do_switch)
      cur_src_q <= want_src;
  end

  // ticks closer than MIN_GAP are held back, no runt phases
  assign emit = cur_tick && !clk_stop
                && (gap_q >= 8'(MIN_GAP - 1));

  // cycles since the last processor tick, saturating
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      gap_q <= '0;
    else if (emit)
      gap_q <= '0;
    else
      gap_q <= sat_inc8(gap_q);
  end

  //------------------------------------------------------------
  // quiet detection of the current source
  //------------------------------------------------------------
  // cycles since the current source last ticked, saturating; a dead source
  // (a synthesizer just powered down) is left after SWITCH_TIMEOUT cycles
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      idle_q <= '0;
    else if (cur_tick || do_switch)
      idle_q <= '0;
    else
      idle_q <= sat_inc8(idle_q);
  end

  //------------------------------------------------------------
  // registered outputs
  //------------------------------------------------------------
  // processor clock enable, gated by the stop pin
  // a tick dropped for spacing or by the stop pin is not made up later
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      proc_clk_en <= 1'h0;
    else
      proc_clk_en <= emit;
  end

  // status seen by the rest of the processor
  // each status follows its source one cycle late
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      active_src    <= clk_sel_pkg::RST_ACTIVE;
      synth_powered <= clk_sel_pkg::RST_SYNTH_PWR;
      synth_locked  <= 1'h0;
      clk_stopped   <= 1'h0;
    end
    else
    begin
      active_src    <= cur_src_q;
      synth_powered <= synth_pwr_q;
      synth_locked  <= synth_lock;
      clk_stopped   <= clk_stop;
    end
  end

endmodule : clk_source_sel

// file: bench/ext_clk_src.sv
// free running external input clock source seen as a sampled level
`timescale 1ns/10ps
module ext_clk_src #(
  parameter int PERIOD = 10
) (
  // clock
  input  wire logic core_clk,
  // generated input clock level
  output logic      clk_out
);
  int cnt_q = 0;
  // phase counter, clock runs free as a real oscillator does
  always_ff @(posedge core_clk)
    cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
  assign clk_out = (cnt_q < PERIOD / 2);
endmodule : ext_clk_src

// file: bench/clk_source_sel_properties.sv
// assertions on the ports of the processor clock source selector
`timescale 1ns/10ps
module clk_sel_checker #(
  parameter int SLOW_DIV       = clk_sel_pkg::SLOW_DIV,
  parameter int SWITCH_TIMEOUT = clk_sel_pkg::SWITCH_TIMEOUT
) (
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic       synth_sel,
  input wire logic       slow_sel,
  input wire logic       clk_stop,
  input wire logic       proc_clk_en,
  input wire logic [1:0] active_src,
  input wire logic       synth_powered,
  input wire logic       synth_locked,
  input wire logic       clk_stopped
);
  localparam int SETTLE = 2 * (SWITCH_TIMEOUT + SLOW_DIV) + 40;
  logic [15:0] hold_q;
  logic [1:0]  sel_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // cycles the selections have stayed unchanged
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
    begin
      hold_q <= '0;
      sel_q  <= '0;
    end
    else
    begin
      sel_q  <= {synth_sel, slow_sel};
      hold_q <= ({synth_sel, slow_sel} != sel_q) ? '0 : hold_q + {15'h0, hold_q != 16'hFFFF};
    end
  AST_POWER_OFF: assert property (!synth_sel [*2] |=> !synth_powered)
    else $error("synthesizer powered while deselected");
  // status lags the selection by two edges, also across a reset release
  AST_POWER_ON: assert property (synth_sel [*3] |=> synth_powered)
    else $error("selected synthesizer not powered");
  AST_SLOW_WINS: assert property (
    slow_sel && sel_q[0] && hold_q >= SETTLE |-> active_src == 2'h2)
    else $error("slow clock not in use");
  AST_INPUT_IDLE: assert property (
    sel_q == 2'h0 && !synth_sel && !slow_sel && hold_q >= SETTLE |-> active_src == 2'h0)
    else $error("input clock not in use");
  AST_SYNTH_LOCK: assert property ($rose(active_src == 2'h1) |-> synth_locked)
    else $error("switched to unlocked synthesizer");
  AST_MIN_GAP: assert property (proc_clk_en |=> !proc_clk_en)
    else $error("processor clock pulses too close");
  AST_STOP_HALT: assert property (clk_stop [*4] |=> !proc_clk_en)
    else $error("processor clock runs while stopped");
  AST_STOP_FLAG: assert property (clk_stop |=> clk_stopped)
    else $error("stop not reported");
endmodule : clk_sel_checker
bind clk_source_sel clk_sel_checker #(.SLOW_DIV(SLOW_DIV), .SWITCH_TIMEOUT(SWITCH_TIMEOUT)) u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .synth_sel(synth_sel), .slow_sel(slow_sel),
  .clk_stop(clk_stop), .proc_clk_en(proc_clk_en), .active_src(active_src),
  .synth_powered(synth_powered), .synth_locked(synth_locked), .clk_stopped(clk_stopped));

// file: bench/tb.sv
// self-checking testbench of the processor clock source selector
`timescale 1ns/10ps
module tb;
  logic       core_clk = 0, arst_n = 0, alt_in_sel = 0, synth_sel = 0, slow_sel = 0, clk_stop = 0;
  logic       ext_clock_in, ext_clock_in_alt, proc_clk_en, synth_powered, synth_locked;
  logic       clk_stopped;
  logic [1:0] active_src;
  logic [7:0] c;
  int         n_errors = 0, tests_run = 0;
  always #10 core_clk = ~core_clk;
  ext_clk_src #(.PERIOD(10)) u_src (.core_clk(core_clk), .clk_out(ext_clock_in));
  ext_clk_src #(.PERIOD(20)) u_alt (.core_clk(core_clk), .clk_out(ext_clock_in_alt));
  clk_source_sel #(.SLOW_DIV(8), .SWITCH_TIMEOUT(20)) u_dut (.core_clk(core_clk),
    .arst_n(arst_n), .ext_clock_in(ext_clock_in), .ext_clock_in_alt(ext_clock_in_alt),
    .alt_in_sel(alt_in_sel), .synth_sel(synth_sel), .slow_sel(slow_sel), .clk_stop(clk_stop),
    .proc_clk_en(proc_clk_en), .active_src(active_src), .synth_powered(synth_powered),
    .synth_locked(synth_locked), .clk_stopped(clk_stopped));
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // processor clock pulses over n cycles, seen mid-cycle where they are settled
  task automatic count(input int n);
    c = 8'h00;
    repeat (n) @(negedge core_clk) if (proc_clk_en === 1'b1) c++;
  endtask : count
  task automatic settle();
    repeat (80) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle
  task automatic t_input();
    for (int a = 0; a < 2; a++)
    begin
      @(posedge core_clk) alt_in_sel <= a[0];
      settle();
      count(120);
      chk(c, a ? 8'h06 : 8'h0C);
    end
    @(posedge core_clk) alt_in_sel <= 1'b0;
  endtask : t_input
  task automatic t_synth();
    @(posedge core_clk) synth_sel <= 1'b1;
    settle();
    chk({6'h0, active_src}, 8'h01);
    chk({7'h0, synth_locked}, 8'h01);
    count(120);
    chk(c, 8'h30);
  endtask : t_synth
  task automatic t_slow_stop();
    @(posedge core_clk) slow_sel <= 1'b1;
    settle();
    chk({6'h0, active_src}, 8'h02);
    chk({7'h0, synth_powered}, 8'h01);
    count(120);
    chk(c, 8'h0F);
    @(posedge core_clk) clk_stop <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk({7'h0, clk_stopped}, 8'h01);
    count(120);
    chk(c, 8'h00);
    @(posedge core_clk)
    begin
      clk_stop <= 1'b0;
      slow_sel <= 1'b0;
    end
    settle();
    chk({6'h0, active_src}, 8'h01);
    chk({7'h0, clk_stopped}, 8'h00);
  endtask : t_slow_stop
  task automatic t_reset();
    @(posedge core_clk) arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({6'h0, active_src}, 8'h00);
    chk({7'h0, synth_powered}, 8'h00);
    @(posedge core_clk) arst_n <= 1'b1;
    settle();
    chk({6'h0, active_src}, 8'h01);
    @(posedge core_clk) synth_sel <= 1'b0;
    settle();
    chk({6'h0, active_src}, 8'h00);
    chk({7'h0, synth_powered}, 8'h00);
    count(120);
    chk(c, 8'h0C);
  endtask : t_reset
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // watchdog
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk({6'h0, active_src}, 8'h00);
    chk({7'h0, synth_powered}, 8'h00);
    t_input();
    t_synth();
    t_slow_stop();
    t_reset();
    give_verdict();
  end
endmodule : tb
